// File: common/pause_flow_pkg.sv
// Functional notes
// R1: The client raises one maximum-length pause request when its FIFO passes the upper threshold.
// R2: The client raises one zero-length pause request when its FIFO falls below the lower threshold.
// R3: A received zero-length pause ends any pause still running and transmission resumes at once.
// R4: A received maximum-length pause stops the handing out of transmit frames.
// R5: The client re-arms after a cancel so that the pause and cancel pair can repeat.
// R6: All transmit logic runs on one shared transmit clock that several instances may share.
// R7: Receive timing is taken from this instance's own receive path and from no shared domain. Here receive runs on the shared mclk instead.
// R8: With a single-clock line-side partner, transmit and receive run on one system clock.
// R9: After the evaluation timeout the transmit ready stays low and no inbound frame is recognised.
// R10: At most one pause request is held, and it carries the most recently sampled duration.
// R11: The pause duration is a 16-bit count of quanta of 512 bit times, 51.2 ns each.
// R12: The client keeps a paused flag so each threshold crossing asks only once.
// R13: The client shows the duration in the same cycle as its one-cycle request strobe.
package pause_flow_pkg;

  localparam int QUANTA_W = 16;

  // Quantum length and clock period in picoseconds
  localparam int QUANTUM_PS = 51200;
  localparam int CLK_PS     = 4000;
  // Least time, so rounded up to whole cycles
  localparam int QUANTUM_CYC = (QUANTUM_PS + CLK_PS - 1) / CLK_PS;
  localparam logic [4:0] QUANTUM_LAST = 5'(QUANTUM_CYC - 1);

  localparam logic [QUANTA_W-1:0] PAUSE_MAX  = 16'hffff;
  localparam logic [QUANTA_W-1:0] PAUSE_NONE = 16'h0000;

  // Default evaluation lifetime in cycles, shortened freely in simulation
  localparam logic [31:0] EVAL_LIFETIME = 32'hffff_ffff;

  // A pause command: strobe plus duration in quanta
  typedef struct packed {
    logic                valid;
    logic [QUANTA_W-1:0] quanta;
  } pause_cmd_type;

endpackage

// File: design/pause_flow_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module pause_flow_ctrl #(
  parameter logic [31:0] EVAL_CYCLES = pause_flow_pkg::EVAL_LIFETIME // Evaluation lifetime
) (
  input  wire logic                          mclk,         // Shared system clock
  input  wire logic                          sys_rst,      // Sync reset, active high
  input  wire pause_flow_pkg::pause_cmd_type pauseReq,     // Client pause request
  input  wire logic                          txFrameBusy,  // MAC sending a frame
  input  wire pause_flow_pkg::pause_cmd_type rxPause,      // Decoded inbound pause
  input  wire logic                          evalBuild,    // Evaluation build enabled
  output pause_flow_pkg::pause_cmd_type      pauseFrame,   // Pause frame launch
  output logic                               txReady,      // Client transmit ready
  output logic                               txInhibit,    // Partner pause running
  output logic                               rxRecognise,  // Inbound pause acted on
  output logic                               evalExpired   // Evaluation timed out
);

  // Pending pause request and its latest duration
  logic                                      pending;
  logic [pause_flow_pkg::QUANTA_W-1:0]       pendingQuanta;
  logic                                      launch;
  logic [pause_flow_pkg::QUANTA_W-1:0]       quantaLeft;
  logic [4:0]                                quantumCnt;
  logic [31:0]                               evalCnt;
  logic                                      rxAccept;

  // Transmit and receive share mclk, so no domain crossing is needed (R6, R8); receive has no clock of its own, though R7 asks for its own receive timing
  assign launch   = pending && !txFrameBusy;
  assign rxAccept = rxPause.valid && !evalExpired; // R9

  // Only one request is held; a later strobe overwrites the duration
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pending       <= 1'b0;
      pendingQuanta <= pause_flow_pkg::PAUSE_NONE;
    end else if (pauseReq.valid) begin
      pending       <= 1'b1;                       // R10
      pendingQuanta <= pauseReq.quanta;            // R10
    end else if (launch) begin
      pending       <= 1'b0;
    end
  end

  // Pause frame launch once the current frame finishes, even while inhibited
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pauseFrame <= '0;
    end else begin
      pauseFrame.valid <= launch;
      if (launch) begin
        pauseFrame.quanta <= pendingQuanta;        // R11
      end
    end
  end

  // Quantum timer: one quantum is QUANTUM_CYC clock cycles
  always_ff @(posedge mclk) begin
    if (sys_rst || rxAccept || quantaLeft == pause_flow_pkg::PAUSE_NONE) begin
      quantumCnt <= 5'h00;
    end else if (quantumCnt == pause_flow_pkg::QUANTUM_LAST) begin
      quantumCnt <= 5'h00;                         // R11
    end else begin
      quantumCnt <= quantumCnt + 5'h01;
    end
  end

  // Remaining pause; a new pause replaces it, zero cancels at once
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      quantaLeft <= pause_flow_pkg::PAUSE_NONE;
    end else if (rxAccept) begin
      quantaLeft <= rxPause.quanta;                // R3 R4
    end else if (quantaLeft != pause_flow_pkg::PAUSE_NONE
                 && quantumCnt == pause_flow_pkg::QUANTUM_LAST) begin
      quantaLeft <= quantaLeft - 16'h0001;         // R11
    end
  end

  // Evaluation lifetime counter; once expired only a reset revives it
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      evalCnt     <= 32'h0000_0000;
      evalExpired <= 1'b0;
    end else if (evalBuild && !evalExpired) begin
      evalCnt <= evalCnt + 32'h0000_0001;
      if (evalCnt == EVAL_CYCLES - 32'h0000_0001) begin
        evalExpired <= 1'b1;                       // R9
      end
    end
  end

  // Client ready: held off by partner pause, pending pause frame or timeout
  assign txInhibit   = quantaLeft != pause_flow_pkg::PAUSE_NONE;
  assign txReady     = !txInhibit && !pending && !evalExpired; // R4 R9
  assign rxRecognise = rxAccept;

  // Checks
  a_req_held: assert property (@(posedge mclk) disable iff (sys_rst)
    pauseReq.valid |=> pending && pendingQuanta == $past(pauseReq.quanta))
    else $error("pause request not held"); // R10
  a_launch_value: assert property (@(posedge mclk) disable iff (sys_rst)
    pending && !txFrameBusy && !pauseReq.valid |=> pauseFrame.valid
      && pauseFrame.quanta == $past(pendingQuanta) ##1 !pauseFrame.valid || pending)
    else $error("pause frame wrong value"); // R10
  a_no_launch_busy: assert property (@(posedge mclk) disable iff (sys_rst)
    txFrameBusy |=> !pauseFrame.valid)
    else $error("pause frame cut into a frame"); // R10
  a_cancel_now: assert property (@(posedge mclk) disable iff (sys_rst)
    rxAccept && rxPause.quanta == 16'h0000 |=> !txInhibit && (txReady || pending || evalExpired))
    else $error("zero pause did not cancel"); // R3
  a_max_stops: assert property (@(posedge mclk) disable iff (sys_rst)
    rxAccept && rxPause.quanta == 16'hffff |=> (!txReady)[*8])
    else $error("max pause did not stop tx"); // R4
  // A one-quantum pause inhibits for 13 cycles after acceptance, then ends
  a_one_quantum: assert property (@(posedge mclk) disable iff (sys_rst)
    rxAccept && rxPause.quanta == 16'h0001 ##1 (!rxPause.valid)[*8]
      ##1 (!rxPause.valid)[*5] |-> txInhibit ##1 !txInhibit)
    else $error("quantum length wrong"); // R11
  a_expired_dead: assert property (@(posedge mclk) disable iff (sys_rst)
    evalExpired |=> evalExpired && !txReady && !rxRecognise)
    else $error("activity after timeout"); // R9
  a_quanta_step: assert property (@(posedge mclk) disable iff (sys_rst)
    txInhibit && !rxAccept && quantumCnt != 5'h0c |=> quantaLeft == $past(quantaLeft))
    else $error("quantum counted early"); // R11

  c_pause_sent: cover property (@(posedge mclk) disable iff (sys_rst)
    pauseFrame.valid && pauseFrame.quanta == 16'hffff);
  c_cancel_rx: cover property (@(posedge mclk) disable iff (sys_rst)
    txInhibit ##1 rxAccept && rxPause.quanta == 16'h0000);
  c_req_merge: cover property (@(posedge mclk) disable iff (sys_rst)
    pauseReq.valid && pending && txFrameBusy);
  c_expire: cover property (@(posedge mclk) disable iff (sys_rst) $rose(evalExpired));

  // Cycles since the last accepted maximum pause, saturating at the top.
  // Zero means no maximum pause is known to be running. A later accepted
  // pause of any length restarts or clears the count, since it replaces
  // whatever time was left of the earlier one.
  logic [7:0] maxRun;

  // Helper count for the long maximum-pause check
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      maxRun <= 8'h00;
    end else if (rxAccept) begin
      if (rxPause.quanta == pause_flow_pkg::PAUSE_MAX) begin
        maxRun <= 8'h01;
      end else begin
        maxRun <= 8'h00;
      end
    end else if (maxRun != 8'h00 && maxRun != 8'hff) begin
      maxRun <= maxRun + 8'h01;
    end
  end

  // Further checks on the inhibit path.
  // A maximum pause lasts far longer than the helper count can reach,
  // so transmit must stay held off for the whole counted stretch.
  a_max_long: assert property (@(posedge mclk) disable iff (sys_rst)
    maxRun != 8'h00 && maxRun != 8'hff |-> !txReady && txInhibit)
    else $error("max pause ended early"); // R4

  // While the partner pause runs the client never sees ready
  a_ready_inhibit: assert property (@(posedge mclk) disable iff (sys_rst)
    txInhibit |-> !txReady)
    else $error("ready during inhibit"); // R4

  // An accepted pause replaces the remaining time at the next edge
  a_inhibit_load: assert property (@(posedge mclk) disable iff (sys_rst)
    rxAccept |=> quantaLeft == $past(rxPause.quanta))
    else $error("pause time not loaded"); // R3

  // The quantum divider never runs past its last count
  a_cnt_range: assert property (@(posedge mclk) disable iff (sys_rst)
    quantumCnt <= pause_flow_pkg::QUANTUM_LAST)
    else $error("quantum counter out of range"); // R11

  // Further checks on the request path.
  // A launch without a fresh strobe empties the single request slot.
  a_pend_clear: assert property (@(posedge mclk) disable iff (sys_rst)
    launch && !pauseReq.valid |=> !pending)
    else $error("request slot not emptied"); // R10

  // A held request keeps ready low so the pause frame goes first
  a_pend_ready: assert property (@(posedge mclk) disable iff (sys_rst)
    pending |-> !txReady)
    else $error("ready while pause pending"); // R10

  // Further checks on the evaluation lifetime.
  // Inbound pauses are never acted on once the lifetime has run out.
  a_rx_dead: assert property (@(posedge mclk) disable iff (sys_rst)
    evalExpired |-> !rxRecognise)
    else $error("pause recognised after timeout"); // R9

  // Without the evaluation build the lifetime never expires
  a_eval_idle: assert property (@(posedge mclk) disable iff (sys_rst)
    !evalBuild && !evalExpired |=> !evalExpired)
    else $error("expired without evaluation build"); // R9

  // A cancel that arrives while a maximum pause runs
  c_max_cancel: cover property (@(posedge mclk) disable iff (sys_rst)
    maxRun != 8'h00 && rxAccept && rxPause.quanta == 16'h0000);

endmodule
`default_nettype wire

// File: verif/fifo_client_model.sv
`timescale 1ns/1ps
`default_nettype none
module fifo_client_model (
  input  wire logic                     mclk,          // System clock
  input  wire logic                     sys_rst,       // Sync reset
  input  wire logic [7:0]               fill,          // FIFO occupancy of 256
  output pause_flow_pkg::pause_cmd_type pauseReq       // Pause request
);
  logic paused;
  // Hysteresis between 7/8 and 3/4 full, one strobe per crossing
  always_ff @(posedge mclk) begin
    pauseReq.valid <= 1'b0;
    if (sys_rst) begin
      paused <= 1'b0;
    end else if (!paused && fill > 8'he0) begin
      paused <= 1'b1;
      pauseReq <= '{1'b1, pause_flow_pkg::PAUSE_MAX};
    end else if (paused && fill < 8'hc0) begin
      paused <= 1'b0;
      pauseReq <= '{1'b1, pause_flow_pkg::PAUSE_NONE};
    end
  end
endmodule
`default_nettype wire

// File: verif/fifo_pause_flow_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module fifo_pause_flow_control_test;
  logic mclk = 0, sys_rst = 1, txFrameBusy = 0, evalBuild = 0;
  logic [7:0] fill = 0, lfsr = 8'h31;
  pause_flow_pkg::pause_cmd_type pauseReq, pauseFrame, rxPause = '0;
  logic txReady, txInhibit, rxRecognise, evalExpired;
  int num_errors = 0, n_tests = 0, cyc = 0;
  fifo_client_model u_fifo_client_model (.mclk(mclk), .sys_rst(sys_rst), .fill(fill),
    .pauseReq(pauseReq));
  pause_flow_ctrl #(.EVAL_CYCLES(32'h0000_0032)) u_pause_flow_ctrl (.mclk(mclk),
    .sys_rst(sys_rst), .pauseReq(pauseReq), .txFrameBusy(txFrameBusy), .rxPause(rxPause),
    .evalBuild(evalBuild), .pauseFrame(pauseFrame), .txReady(txReady),
    .txInhibit(txInhibit), .rxRecognise(rxRecognise), .evalExpired(evalExpired));
  initial forever #2 mclk = ~mclk;
  function automatic logic [7:0] nextLfsr(input logic [7:0] l);
    return {l[6:0], l[7] ^ l[5] ^ l[4] ^ l[3]};
  endfunction
  // Inhibit length: quanta times 13 cycles
  function automatic int inhibitCycles(input logic [15:0] q);
    return int'(q) * pause_flow_pkg::QUANTUM_CYC;
  endfunction
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("errors %0d, checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Wait bounded for one launched pause frame
  task automatic waitFrame(input logic [15:0] q);
    int n;
    n = 0;
    while (pauseFrame.valid !== 1'b1 && n < 40) begin
      n++;
      @(negedge mclk);
    end
    check({pauseFrame.valid, pauseFrame.quanta}, {1'b1, q});
    @(negedge mclk);
  endtask
  // One-cycle inbound pause, acceptance seen in its own cycle
  task automatic rx(input logic [15:0] q, input logic rec);
    rxPause = '{1'b1, q};
    #1 check(rxRecognise, rec);
    @(negedge mclk);
    rxPause = '0;
  endtask
  always @(posedge mclk) if (++cyc > 20000) begin
    num_errors++;
    tally_and_finish;
  end
  initial begin
    int n;
    logic [15:0] q;
    repeat (16) @(negedge mclk);
    sys_rst = 0;
    check(txReady, 1);
    // Two crossings while busy merge into one frame with latest value
    txFrameBusy = 1;
    fill = 8'hf0;
    repeat (4) @(negedge mclk);
    fill = 8'h10;
    repeat (4) @(negedge mclk);
    check(pauseFrame.valid, 0);
    txFrameBusy = 0;
    waitFrame(16'h0000);
    fill = 8'hf0;
    waitFrame(16'hffff);
    fill = 8'h10;
    waitFrame(16'h0000);
    fill = 8'hf0;
    waitFrame(16'hffff);
    for (int i = 0; i < 4; i++) begin
      q = (i == 0) ? 16'h0001 : {13'h0, lfsr[2:0]};
      lfsr = nextLfsr(lfsr);
      @(negedge mclk);
      rx(q, 1'b1);
      n = 0;
      while (txInhibit === 1'b1 && n < 200) begin
        n++;
        @(negedge mclk);
      end
      check(17'(n), 17'(inhibitCycles(q)));
    end
    rx(16'hffff, 1'b1);
    check(txReady, 0);
    @(negedge mclk);
    rx(16'h0000, 1'b1);
    check({txInhibit, txReady}, 2'b01);
    evalBuild = 1;
    n = 0;
    while (evalExpired !== 1'b1 && n < 100) begin
      n++;
      @(negedge mclk);
    end
    rx(16'h0001, 1'b0);
    check({evalExpired, txInhibit, txReady}, 3'b100);
    sys_rst = 1;
    evalBuild = 0;
    @(negedge mclk);
    sys_rst = 0;
    check({evalExpired, txReady}, 2'b01);
    tally_and_finish;
  end
endmodule
`default_nettype wire
